/* cwt_pkg.sv */
// Package: register map, field layouts and constants for the clock/tick block
package cwt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_PLL_CONTROL  = 8'h06;
  localparam logic [7:0]  IDX_TICK_CONTROL = 8'h07;
  localparam logic [7:0]  IDX_SC_STATUS    = 8'h08;
  localparam logic [1:0]  ADDR_LSB         = 2'h2;

  localparam logic [7:0]  PLL_CONTROL_RESET  = 8'h01;
  localparam logic [7:0]  TICK_CONTROL_RESET = 8'h00;
  // Only bits 5..0 of the pll register live here; 7..6 read zero
  localparam logic [7:0]  PLL_IMPL_MASK      = 8'h3f;

  // Status register bit positions
  localparam int unsigned ST_ACTIVE   = 0;
  localparam int unsigned ST_FLAG     = 1;
  localparam int unsigned ST_OSC_RUN  = 2;
  localparam int unsigned ST_MON_RUN  = 3;
  localparam int unsigned ST_ON_OSC   = 4;

  // Modulation amplitude codes
  localparam logic [1:0]  MOD_OFF   = 2'h0;
  localparam logic [1:0]  MOD_PM1   = 2'h1;
  localparam logic [1:0]  MOD_PM2   = 2'h2;
  localparam logic [1:0]  MOD_PM4   = 2'h3;
  localparam logic [3:0]  MOD_RATE_LAST = 4'hf;

  // Tick prescaler
  localparam int unsigned PRESC_W        = 18;
  localparam logic [2:0]  PRESC_OFF_CODE = 3'h0;
  localparam int unsigned BIN_BASE_EXP   = 9;
  // Decimal prescale lengths, codes 0 to 7
  localparam logic [PRESC_W-1:0] DEC_PRESC_0 = 18'h003e8;
  localparam logic [PRESC_W-1:0] DEC_PRESC_1 = 18'h007d0;
  localparam logic [PRESC_W-1:0] DEC_PRESC_2 = 18'h01388;
  localparam logic [PRESC_W-1:0] DEC_PRESC_3 = 18'h02710;
  localparam logic [PRESC_W-1:0] DEC_PRESC_4 = 18'h04e20;
  localparam logic [PRESC_W-1:0] DEC_PRESC_5 = 18'h0c350;
  localparam logic [PRESC_W-1:0] DEC_PRESC_6 = 18'h186a0;
  localparam logic [PRESC_W-1:0] DEC_PRESC_7 = 18'h30d40;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'b0;

  typedef struct packed {
    logic       unused_hi;
    logic       unused_lo;
    logic       mod_amp_hi;
    logic       mod_amp_lo;
    logic       fast_wake_en;
    logic       tick_pseudo_stop_run;
    logic       watchdog_pseudo_stop_run;
    logic       self_clock_enable;
  } cwt_pll_s;

  typedef struct packed {
    logic       tick_decimal_select;
    logic [2:0] tick_prescale_sel;
    logic [3:0] tick_modulus_sel;
  } cwt_tick_s;

  typedef enum logic [3:0] {
    SC_NORMAL = 4'b0001,
    SC_FAIL   = 4'b0010,
    SC_FAST   = 4'b0100,
    SC_CHECK  = 4'b1000
  } cwt_sc_e;

endpackage

/* cwt_clock_tick_ctrl.sv */
// Clock wake, self-clock, modulation and periodic tick control with AHB slave
module cwt_clock_tick_ctrl
  import cwt_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        i_pll_clock_select,
  input  wire logic        i_special_mode,
  input  wire logic        i_pseudo_stop,
  input  wire logic        i_wait_mode,
  input  wire logic        i_tick_wait_stop,
  input  wire logic        i_full_stop_wake,
  input  wire logic        i_crystal_fail,
  input  wire logic        i_quality_ok,
  input  wire logic        i_osc_clock_en,
  input  wire logic        i_ref_clock_en,
  output logic [1:0]       o_mod_amp,
  output logic             o_mod_step,
  output logic             o_watchdog_run,
  output logic             o_periodic_tick,
  output logic             o_clock_mon_reset,
  output logic             o_self_clock_active,
  output logic             o_osc_enable,
  output logic             o_monitor_enable,
  output logic             o_quality_check_start,
  output logic             o_sys_on_osc
);

  // Bus address and data phase state
  logic            wr_pend_reg;
  logic            rd_pend_reg;
  logic [7:0]      idx_reg;
  logic            hready_reg;
  logic [31:0]     hrdata_reg;

  cwt_pll_s        pll_reg;
  cwt_tick_s       tick_reg;
  logic            self_clock_enable_written_reg;
  logic            flag_reg;
  logic            on_osc_reg;
  cwt_sc_e         sc_reg;
  cwt_sc_e         sc_next;
  logic            sc_active_reg;

  logic [PRESC_W-1:0] presc_cnt_reg;
  logic [3:0]      mod_cnt_reg;
  logic            tick_pulse_reg;
  logic [3:0]      ref_cnt_reg;
  logic            mod_step_reg;
  logic            mon_reset_reg;
  logic            check_start_reg;
  logic            wd_run_reg;

  // Address decode
  wire logic       addr_ok    = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire logic [7:0] addr_idx   = haddr[ADDR_LSB+7:ADDR_LSB];
  wire logic [7:0] wdata      = hwdata[7:0];
  wire logic       wr_pll     = wr_pend_reg & (idx_reg == IDX_PLL_CONTROL);
  wire logic       wr_tick    = wr_pend_reg & (idx_reg == IDX_TICK_CONTROL);
  wire logic       wr_status  = wr_pend_reg & (idx_reg == IDX_SC_STATUS);

  wire cwt_pll_s   pll_wr     = cwt_pll_s'(wdata);
  wire logic       sc_active  = (sc_reg != SC_NORMAL);

  // Self-clock enable: one write in normal modes, never cleared in SELF_CLOCK_ACTIVE
  wire logic       self_clock_enable_may   = i_special_mode | ~self_clock_enable_written_reg;
  wire logic       self_clock_enable_clr_blk = sc_active & ~pll_wr.self_clock_enable;
  wire logic       self_clock_enable_take  = wr_pll & self_clock_enable_may & ~self_clock_enable_clr_blk;
  wire logic       fm_take    = wr_pll & ~i_pll_clock_select;

  // Fast wake counts only with self-clock enabled
  wire logic       fast_wake_on = pll_reg.fast_wake_en &
                                  pll_reg.self_clock_enable;

  // Read mux
  wire logic [7:0] status_rd  = {3'h0, on_osc_reg,
                                 (sc_reg != SC_FAST),
                                 (sc_reg != SC_FAST),
                                 flag_reg, sc_active};
  wire logic [7:0] rd_byte    =
    (idx_reg == IDX_PLL_CONTROL)  ? (pll_reg & PLL_IMPL_MASK) :
    (idx_reg == IDX_TICK_CONTROL) ? tick_reg :
    (idx_reg == IDX_SC_STATUS)    ? status_rd : 8'h00;

  // Reads take one wait state so data always comes from a flip-flop
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      idx_reg     <= 8'h00;
      hready_reg  <= 1'b1;
      hrdata_reg  <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= addr_ok & hwrite;
      rd_pend_reg <= addr_ok & ~hwrite;
      if (addr_ok) begin
        idx_reg <= addr_idx;
      end
      hready_reg <= ~(addr_ok & ~hwrite);
      if (rd_pend_reg) begin
        hrdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Control registers
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pll_reg          <= cwt_pll_s'(PLL_CONTROL_RESET);
      tick_reg         <= cwt_tick_s'(TICK_CONTROL_RESET);
      self_clock_enable_written_reg <= 1'b0;
    end else begin
      if (wr_pll) begin
        pll_reg.fast_wake_en             <= pll_wr.fast_wake_en;
        pll_reg.tick_pseudo_stop_run     <= pll_wr.tick_pseudo_stop_run;
        pll_reg.watchdog_pseudo_stop_run <= pll_wr.watchdog_pseudo_stop_run;
        self_clock_enable_written_reg                 <= 1'b1;
      end
      if (fm_take) begin
        pll_reg.mod_amp_hi <= pll_wr.mod_amp_hi;
        pll_reg.mod_amp_lo <= pll_wr.mod_amp_lo;
      end
      if (self_clock_enable_take) begin
        pll_reg.self_clock_enable <= pll_wr.self_clock_enable;
      end
      if (wr_tick) begin
        tick_reg <= cwt_tick_s'(wdata);
      end
    end
  end

  // Self-clock state machine
  always_comb begin
    sc_next = sc_reg;
    unique case (sc_reg)
      SC_NORMAL: begin
        if (i_crystal_fail & pll_reg.self_clock_enable) begin
          sc_next = SC_FAIL;
        end else if (i_full_stop_wake & fast_wake_on) begin
          sc_next = SC_FAST;
        end
      end
      SC_FAIL: begin
        if (i_quality_ok) begin
          sc_next = SC_NORMAL;
        end
      end
      SC_FAST: begin
        if (~pll_reg.fast_wake_en) begin
          sc_next = SC_CHECK;
        end
      end
      SC_CHECK: begin
        if (i_quality_ok) begin
          sc_next = SC_NORMAL;
        end
      end
    endcase
  end

  wire logic check_pass = (sc_reg == SC_CHECK) & i_quality_ok;
  wire logic fail_pass  = (sc_reg == SC_FAIL) & i_quality_ok;
  wire logic fail_enter = (sc_reg == SC_NORMAL) & i_crystal_fail &
                          pll_reg.self_clock_enable;
  // Hardware set beats a software clear in the same cycle
  wire logic flag_set   = check_pass | fail_enter;
  wire logic flag_clr   = wr_status & wdata[ST_FLAG];

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sc_reg          <= SC_NORMAL;
      sc_active_reg   <= 1'b0;
      flag_reg        <= 1'b0;
      on_osc_reg      <= 1'b1;
      mon_reset_reg   <= 1'b0;
      check_start_reg <= 1'b0;
    end else begin
      sc_reg <= sc_next;
      sc_active_reg <= (sc_next != SC_NORMAL);
      if (flag_set) begin
        flag_reg <= 1'b1;
      end else if (flag_clr) begin
        flag_reg <= 1'b0;
      end
      if (check_pass | fail_pass) begin
        on_osc_reg <= 1'b1;
      end else if (sc_next != SC_NORMAL) begin
        on_osc_reg <= 1'b0;
      end
      mon_reset_reg   <= (sc_reg == SC_NORMAL) & i_crystal_fail &
                         ~pll_reg.self_clock_enable;
      check_start_reg <= (sc_reg == SC_FAST) &
                         ~pll_reg.fast_wake_en;
    end
  end

  // Modulation rate divider on the reference enable
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ref_cnt_reg  <= 4'h0;
      mod_step_reg <= 1'b0;
    end else begin
      mod_step_reg <= 1'b0;
      if (i_ref_clock_en & ({pll_reg.mod_amp_hi, pll_reg.mod_amp_lo}
                            != MOD_OFF)) begin
        ref_cnt_reg <= ref_cnt_reg + 4'h1;
        if (ref_cnt_reg == MOD_RATE_LAST) begin
          mod_step_reg <= 1'b1;
        end
      end
    end
  end

  // Prescale limit from the tick control fields
  function automatic logic [PRESC_W-1:0] presc_last(input cwt_tick_s t);
    logic [PRESC_W-1:0] v;
    v = '0;
    if (t.tick_decimal_select) begin
      unique case (t.tick_prescale_sel)
        3'h0: v = DEC_PRESC_0;
        3'h1: v = DEC_PRESC_1;
        3'h2: v = DEC_PRESC_2;
        3'h3: v = DEC_PRESC_3;
        3'h4: v = DEC_PRESC_4;
        3'h5: v = DEC_PRESC_5;
        3'h6: v = DEC_PRESC_6;
        3'h7: v = DEC_PRESC_7;
      endcase
    end else begin
      v = PRESC_W'(1) << (BIN_BASE_EXP + t.tick_prescale_sel);
    end
    return v - PRESC_W'(1);
  endfunction

  // Binary mode code 000 switches the tick off
  wire logic tick_off   = ~tick_reg.tick_decimal_select &
                          (tick_reg.tick_prescale_sel == PRESC_OFF_CODE);
  // Pseudo stop halts without clearing; wait stop clears
  wire logic tick_hold  = i_pseudo_stop & ~pll_reg.tick_pseudo_stop_run;
  wire logic tick_init  = wr_tick | tick_off |
                          (i_wait_mode & i_tick_wait_stop);
  wire logic tick_step  = i_osc_clock_en & ~tick_hold;
  wire logic presc_wrap = (presc_cnt_reg == presc_last(tick_reg));
  wire logic mod_wrap   = (mod_cnt_reg == tick_reg.tick_modulus_sel);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      presc_cnt_reg  <= '0;
      mod_cnt_reg    <= 4'h0;
      tick_pulse_reg <= 1'b0;
    end else begin
      tick_pulse_reg <= 1'b0;
      if (tick_init) begin
        presc_cnt_reg <= '0;
        mod_cnt_reg   <= 4'h0;
      end else if (tick_step) begin
        if (presc_wrap) begin
          presc_cnt_reg <= '0;
          if (mod_wrap) begin
            mod_cnt_reg    <= 4'h0;
            tick_pulse_reg <= 1'b1;
          end else begin
            mod_cnt_reg <= mod_cnt_reg + 4'h1;
          end
        end else begin
          presc_cnt_reg <= presc_cnt_reg + PRESC_W'(1);
        end
      end
    end
  end

  // Watchdog gate: frozen in pseudo stop, wait reinit stays elsewhere
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wd_run_reg <= 1'b1;
    end else begin
      wd_run_reg <= ~(i_pseudo_stop &
                      ~pll_reg.watchdog_pseudo_stop_run);
    end
  end

  // Oscillator and monitor are off only during a fast wake
  logic osc_en_reg;
  logic amp_hi_reg;
  logic amp_lo_reg;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      osc_en_reg <= 1'b1;
      amp_hi_reg <= 1'b0;
      amp_lo_reg <= 1'b0;
    end else begin
      osc_en_reg <= (sc_next != SC_FAST);
      amp_hi_reg <= pll_reg.mod_amp_hi;
      amp_lo_reg <= pll_reg.mod_amp_lo;
    end
  end

  assign hreadyout             = hready_reg;
  assign hresp                 = HRESP_OKAY;
  assign hrdata                = hrdata_reg;
  assign o_mod_amp             = {amp_hi_reg, amp_lo_reg};
  assign o_mod_step            = mod_step_reg;
  assign o_watchdog_run        = wd_run_reg;
  assign o_periodic_tick       = tick_pulse_reg;
  assign o_clock_mon_reset     = mon_reset_reg;
  assign o_self_clock_active   = sc_active_reg;
  assign o_osc_enable          = osc_en_reg;
  assign o_monitor_enable      = osc_en_reg;
  assign o_quality_check_start = check_start_reg;
  assign o_sys_on_osc          = on_osc_reg;

endmodule

/* cwt_ctrl_asserts.sv */
// Checker: port-level assertions for the clock and tick control block
module cwt_ctrl_asserts
  import cwt_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        i_pll_clock_select,
  input wire logic        i_pseudo_stop,
  input wire logic        i_crystal_fail,
  input wire logic        i_quality_ok,
  input wire logic        i_osc_clock_en,
  input wire logic [1:0]  o_mod_amp,
  input wire logic        o_watchdog_run,
  input wire logic        o_periodic_tick,
  input wire logic        o_clock_mon_reset,
  input wire logic        o_self_clock_active,
  input wire logic        o_osc_enable,
  input wire logic        o_sys_on_osc
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire req   = hsel && hready && htrans == HTRANS_NONSEQ;
  wire tk_wr = req && hwrite && haddr[9:2] == IDX_TICK_CONTROL;

  a_read_wait: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase lacks one wait state");
  a_amp_frozen: assert property (
    i_pll_clock_select [*2] |=> $stable(o_mod_amp))
    else $error("amplitude changed while pll clock selected");
  a_wd_gate: assert property (!i_pseudo_stop |=> o_watchdog_run)
    else $error("watchdog halted outside pseudo stop");
  a_tick_cause: assert property (o_periodic_tick |-> $past(i_osc_clock_en))
    else $error("tick without oscillator step");
  // Skip three cycles: a tick already in flight may still leave
  a_tick_restart: assert property (tk_wr |-> ##3 !o_periodic_tick [*8])
    else $error("tick too soon after tick register write");
  a_mon_reset: assert property (o_clock_mon_reset |->
    $past(i_crystal_fail) && !$past(o_self_clock_active))
    else $error("monitor reset without crystal failure");
  a_osc_off: assert property (!o_osc_enable |-> o_self_clock_active)
    else $error("oscillator off outside self clock");
  a_on_osc: assert property ($rose(o_sys_on_osc) |->
    $past(i_quality_ok) && !o_self_clock_active)
    else $error("switch to oscillator without quality pass");
endmodule

bind cwt_clock_tick_ctrl cwt_ctrl_asserts i_chk (.*);

/* cwt_clock_tick_ctrl_tb_top.sv */
// Testbench: bus, tick and self-clock scenarios for the clock block
module cwt_clock_tick_ctrl_tb_top
  import cwt_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_core_clk, i_rst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [2:0]  hsize, ev;
  logic [7:0]  tf;
  logic [1:0]  htrans, o_mod_amp;
  logic        i_pll_clock_select, i_special_mode, i_pseudo_stop;
  logic        i_wait_mode, i_tick_wait_stop, i_osc_clock_en;
  logic        i_ref_clock_en, o_mod_step, o_watchdog_run;
  logic        o_periodic_tick, o_clock_mon_reset, o_self_clock_active;
  logic        o_osc_enable, o_monitor_enable, o_quality_check_start;
  logic        o_sys_on_osc, mr;
  int          fail_count, check_count, n, m;
  wire         hready = hreadyout;
  wire         i_crystal_fail = ev[0];
  wire         i_quality_ok = ev[1];
  wire         i_full_stop_wake = ev[2];

  cwt_clock_tick_ctrl i_dut (.*);

  always #2 i_core_clk = ~i_core_clk;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Expected oscillator steps per tick for a tick register value
  function automatic int tick_period(input logic [7:0] f);
    int b;
    case (f[6:4])
      3'h0: b = DEC_PRESC_0;
      3'h1: b = DEC_PRESC_1;
      3'h2: b = DEC_PRESC_2;
      3'h3: b = DEC_PRESC_3;
      3'h4: b = DEC_PRESC_4;
      3'h5: b = DEC_PRESC_5;
      3'h6: b = DEC_PRESC_6;
      3'h7: b = DEC_PRESC_7;
    endcase
    if (!f[7]) b = (f[6:4] == 3'h0) ? 0 : 1 << (BIN_BASE_EXP + f[6:4]);
    return b * (f[3:0] + 1);
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, output logic [31:0] q);
    int k;
    k = 0;
    hsel <= 1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    do begin @(posedge i_core_clk); k++; end while (hready !== 1 && k < 50);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do begin @(posedge i_core_clk); k++; end while (hready !== 1 && k < 50);
    q = hrdata;
    chk(hresp, HRESP_OKAY);
    if (k >= 50) begin
      fail_count++;
      wrap_up();
    end
  endtask

  // One-cycle event pulse; monitor reset is collected on the way
  task automatic pulse(input int b);
    ev[b] <= 1;
    @(posedge i_core_clk);
    ev[b] <= 0;
    repeat (3) begin
      @(posedge i_core_clk);
      mr |= o_clock_mon_reset;
    end
  endtask

  // Oscillator steps between two ticks; frozen or idle cycles not counted
  task automatic meas(input bit frz, input bit slow, output int c);
    int k;
    k = 0;
    do begin
      @(posedge i_core_clk);
      k++;
      i_osc_clock_en <= !slow || !i_osc_clock_en;
    end while (o_periodic_tick !== 1 && k < 20000);
    if (k >= 20000) begin
      fail_count++;
      wrap_up();
    end
    // The edge that shows the tick may already carry a step
    c = i_osc_clock_en;
    for (k = 0; k < 20000; k++) begin
      @(posedge i_core_clk);
      if (o_periodic_tick === 1) break;
      if (!i_pseudo_stop && i_osc_clock_en) c++;
      i_pseudo_stop <= frz && k >= 500 && k < 800;
      i_osc_clock_en <= !slow || !i_osc_clock_en;
      if (k == 700) chk(o_watchdog_run, !frz);
    end
    i_osc_clock_en <= 1;
    if (k >= 20000) begin
      fail_count++;
      wrap_up();
    end
  endtask

  initial begin
    {i_core_clk, hsel, hwrite, i_pll_clock_select, i_special_mode} = '0;
    {i_pseudo_stop, i_wait_mode, i_tick_wait_stop, i_ref_clock_en} = '0;
    {mr, ev, haddr, hwdata, htrans, n} = '0;
    i_osc_clock_en = 1;
    i_rst = 1;
    hsize = 3'h2;
    fail_count = 0;
    check_count = 0;
    void'($urandom(32'hf10b));
    repeat (2) @(posedge i_core_clk);
    i_rst <= 0;
    @(posedge i_core_clk);
    chk(o_watchdog_run, 1);
    bus(0, IDX_PLL_CONTROL, 8'h0, r);
    chk(r, PLL_CONTROL_RESET);
    bus(0, IDX_TICK_CONTROL, 8'h0, r);
    chk(r, 0);
    bus(1, 8'h3f, 8'ha5, r);
    bus(0, 8'h3f, 8'h0, r);
    chk(r, 0);
    $display("done: reset and map");
    for (int c = 0; c < 4; c++) begin
      bus(1, IDX_PLL_CONTROL, {2'h0, c[1:0], 4'h1}, r);
      repeat (2) @(posedge i_core_clk);
      chk(o_mod_amp, c[1:0]);
    end
    i_pll_clock_select <= 1;
    bus(1, IDX_PLL_CONTROL, 8'h01, r);
    bus(0, IDX_PLL_CONTROL, 8'h0, r);
    chk(r[5:4], 2'h3);
    i_pll_clock_select <= 0;
    for (int k = 0; k < 68; k++) begin
      @(posedge i_core_clk);
      i_ref_clock_en <= k < 64 && !i_ref_clock_en;
      n += o_mod_step;
    end
    chk(n, 2);
    $display("done: modulation");
    for (int t = 0; t < 3; t++) begin
      m = (t == 2) ? 0 : $urandom % 4;
      tf = {t == 0, 2'h0, t != 0, m[3:0]};
      bus(1, IDX_TICK_CONTROL, tf, r);
      meas(t == 2, t == 1, n);
      chk(n, tick_period(tf));
    end
    // Wait stop holds the tick divider at zero
    i_wait_mode <= 1;
    i_tick_wait_stop <= 1;
    n = 0;
    repeat (1500) begin
      @(posedge i_core_clk);
      n += o_periodic_tick;
    end
    chk(n, 0);
    i_wait_mode <= 0;
    i_tick_wait_stop <= 0;
    bus(1, IDX_TICK_CONTROL, 8'h05, r);
    n = 0;
    repeat (3000) begin
      @(posedge i_core_clk);
      n += o_periodic_tick;
    end
    chk(n, tick_period(8'h05));
    $display("done: tick");
    pulse(0);
    chk(o_self_clock_active, 1);
    pulse(1);
    chk(o_sys_on_osc, 1);
    bus(1, IDX_SC_STATUS, 8'h02, r);
    bus(1, IDX_PLL_CONTROL, 8'h09, r);
    pulse(2);
    bus(0, IDX_SC_STATUS, 8'h0, r);
    chk(r[ST_FLAG], 0);
    chk(o_self_clock_active, 1);
    chk(o_osc_enable, 0);
    chk(o_monitor_enable, 0);
    bus(1, IDX_PLL_CONTROL, 8'h01, r);
    @(posedge i_core_clk);
    chk(o_quality_check_start, 0);
    @(posedge i_core_clk);
    chk(o_quality_check_start, 1);
    chk(o_osc_enable, 1);
    chk(o_monitor_enable, 1);
    pulse(1);
    bus(0, IDX_SC_STATUS, 8'h0, r);
    chk(r[ST_FLAG], 1);
    chk(o_sys_on_osc, 1);
    bus(1, IDX_PLL_CONTROL, 8'h00, r);
    bus(0, IDX_PLL_CONTROL, 8'h0, r);
    chk(r[0], 1);
    i_special_mode <= 1;
    bus(1, IDX_PLL_CONTROL, 8'h08, r);
    mr = 0;
    pulse(0);
    chk(mr, 1);
    chk(o_self_clock_active, 0);
    pulse(2);
    chk(o_self_clock_active, 0);
    $display("done: self clock");
    wrap_up();
  end
endmodule
